// file: verilog/ddc_pkg.sv
// Constants for the driver control/status word 0 upper fields.
// Assumes a 20 MHz system clock and a mode-0, LSB-first serial link.
package ddc_pkg;
	// ==========================================================
	// Word layout
	localparam int unsigned WORD_W       = 24;
	localparam int unsigned CNT_W        = 5;
	localparam logic [4:0]  FRAME_BITS   = 5'h18;
	localparam int unsigned SEL_BIT      = 0;
	localparam int unsigned CTL_ENABLE   = 23;
	localparam int unsigned CTL_STAT_CLR = 22;
	localparam int unsigned CTL_RATIO    = 21;
	localparam int unsigned CTL_REC_DIS  = 20;
	localparam int unsigned CTL_MON_HI   = 19;
	localparam int unsigned CTL_MON_LO   = 18;
	// Monitor select codes {bit19,bit18} and one-hot source {out4,out5,out1,out8}
	localparam logic [1:0]  MON_OUT8     = 2'h0;
	localparam logic [1:0]  MON_OUT1     = 2'h2;
	localparam logic [1:0]  MON_OUT5     = 2'h1;
	localparam logic [1:0]  MON_OUT4     = 2'h3;
	localparam logic [3:0]  SRC_OUT8     = 4'h1;
	localparam logic [3:0]  SRC_OUT1     = 4'h2;
	localparam logic [3:0]  SRC_OUT5     = 4'h4;
	localparam logic [3:0]  SRC_OUT4     = 4'h8;
	// ==========================================================
	// Reset values
	localparam logic [WORD_W-1:0] SHIFT_RST = 24'h000000;
	localparam logic [1:0]  MON_RST      = 2'h0;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_NS       = 50;
	localparam int unsigned SETTLE_NS    = 40000;
	localparam int unsigned SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TMR_W        = 10;
endpackage

// file: verilog/ddc_top.sv
// Serial control word 0 upper fields and status word 0 upper flags.
// Assumes the link pins and the supply/thermal monitors are asynchronous.
`timescale 1ns/10ps

// Function
// - A valid word-0 write with enable zero enters standby and clears status; with one, active.
// - Writing the status-reset bit clears the supply and thermal flags (bits 22:19), not the not-ready bit, when the frame ends.
// - Bit 21 selects a 12 percent (0) or 25 percent (1) over-current retry ratio.
// - Bits 19:18 steer the monitor to out8, out1, out5, out4 for 00, 10, 01, 11.
// - Supply over/undervoltage sets bit 22 or 21 and switches outputs off.
// - Outputs return by themselves when the supply recovers unless bit 20 holds them off.
// - Thermal shutdown sets bit 20 and keeps outputs off while that flag stays set.
// - Thermal warning sets bit 19 and affects no output.
// - Going from standby to active sets bit 18 and holds outputs off during settling.
// - The not-ready bit clears by itself when the settling count ends.
module ddc_top
	import ddc_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic       spi_clk_i,
	input  wire logic       spi_data_in_i,
	input  wire logic       frame_select_low_i,
	input  wire logic       supply_over_i,
	input  wire logic       supply_under_i,
	input  wire logic       thermal_shutdown_i,
	input  wire logic       thermal_warning_i,
	output logic            spi_data_out_o,
	output logic            spi_data_out_oen_o,
	output logic            outputs_enable_o,
	output logic            standby_o,
	output logic            overcurrent_retry_ratio_o,
	output logic [3:0]      current_image_output_o
);
	// ==========================================================
	// Input synchronisers
	logic [6:0]        sync1_q;
	logic [6:0]        sync2_q;
	logic              sclk_d_q;
	logic              csn_d_q;
	logic              sclk_s;
	logic              di_s;
	logic              csn_s;
	logic              ov_s;
	logic              uv_s;
	logic              tsd_s;
	logic              tw_s;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			sync1_q  <= 7'h04;
			sync2_q  <= 7'h04;
			sclk_d_q <= 1'b0;
			csn_d_q  <= 1'b1;
		end else begin
			sync1_q  <= {thermal_warning_i, thermal_shutdown_i, supply_under_i,
				supply_over_i, frame_select_low_i, spi_data_in_i, spi_clk_i};
			sync2_q  <= sync1_q;
			sclk_d_q <= sclk_s;
			csn_d_q  <= csn_s;
		end
	end

	assign sclk_s = sync2_q[0];
	assign di_s   = sync2_q[1];
	assign csn_s  = sync2_q[2];
	assign ov_s   = sync2_q[3];
	assign uv_s   = sync2_q[4];
	assign tsd_s  = sync2_q[5];
	assign tw_s   = sync2_q[6];

	logic sclk_rise;
	logic sclk_fall;
	logic csn_fall;
	logic csn_rise;
	assign sclk_rise = sclk_s & ~sclk_d_q & ~csn_s;
	assign sclk_fall = ~sclk_s & sclk_d_q & ~csn_s;
	assign csn_fall  = ~csn_s & csn_d_q;
	assign csn_rise  = csn_s & ~csn_d_q;

	// ==========================================================
	// Serial frame
	logic [WORD_W-1:0] in_sh_q;
	logic [WORD_W-1:0] out_sh_q;
	logic [CNT_W-1:0]  bit_cnt_q;
	logic              first_q;
	logic              commit;
	logic [WORD_W-1:0] wdata;
	logic [WORD_W-1:0] stat0;
	logic              fault;

	assign wdata  = in_sh_q;
	assign commit = csn_rise & (bit_cnt_q == FRAME_BITS) & ~in_sh_q[SEL_BIT];

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			in_sh_q   <= SHIFT_RST;
			bit_cnt_q <= '0;
		end else if (csn_fall) begin
			bit_cnt_q <= '0;
		end else if (sclk_rise) begin
			in_sh_q <= {di_s, in_sh_q[WORD_W-1:1]};
			if (bit_cnt_q != '1) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			out_sh_q           <= SHIFT_RST;
			first_q            <= 1'b0;
			spi_data_out_o     <= 1'b0;
			spi_data_out_oen_o <= 1'b1;
		end else begin
			spi_data_out_oen_o <= csn_s;
			if (csn_fall) begin
				first_q        <= 1'b1;
				spi_data_out_o <= fault;
			end else if (sclk_rise && first_q) begin
				first_q  <= 1'b0;
				// Word 1 is not held here and reads as the fault bit only
				out_sh_q <= di_s ? {23'h000000, fault} : stat0;
			end else if (sclk_fall && !first_q) begin
				spi_data_out_o <= out_sh_q[1];
				out_sh_q       <= {1'b0, out_sh_q[WORD_W-1:1]};
			end
		end
	end

	// ==========================================================
	// Control word 0
	logic       active_q;
	logic       rec_dis_q;
	logic [1:0] mon_q;
	logic       clr;
	assign clr = commit & (~wdata[CTL_ENABLE] | wdata[CTL_STAT_CLR]);

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			active_q                  <= 1'b0;
			rec_dis_q                 <= 1'b0;
			mon_q                     <= MON_RST;
			overcurrent_retry_ratio_o <= 1'b0;
		end else if (commit) begin
			active_q                  <= wdata[CTL_ENABLE];
			rec_dis_q                 <= wdata[CTL_REC_DIS];
			mon_q                     <= wdata[CTL_MON_HI:CTL_MON_LO];
			overcurrent_retry_ratio_o <= wdata[CTL_RATIO];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			current_image_output_o <= SRC_OUT8;
		end else begin
			case (mon_q)
				MON_OUT8: current_image_output_o <= SRC_OUT8;
				MON_OUT1: current_image_output_o <= SRC_OUT1;
				MON_OUT5: current_image_output_o <= SRC_OUT5;
				MON_OUT4: current_image_output_o <= SRC_OUT4;
				default:  current_image_output_o <= SRC_OUT8;
			endcase
		end
	end

	// ==========================================================
	// Status flags, set wins over clear
	logic             ov_q;
	logic             uv_q;
	logic             tsd_q;
	logic             tw_q;
	logic             nr_q;
	logic [TMR_W-1:0] tmr_q;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ov_q  <= 1'b0;
			uv_q  <= 1'b0;
			tsd_q <= 1'b0;
			tw_q  <= 1'b0;
		end else begin
			ov_q  <= ov_s | (ov_q & ~clr);
			uv_q  <= uv_s | (uv_q & ~clr);
			tsd_q <= tsd_s | (tsd_q & ~clr);
			tw_q  <= tw_s | (tw_q & ~clr);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			nr_q  <= 1'b0;
			tmr_q <= '0;
		end else if (commit && !wdata[CTL_ENABLE]) begin
			nr_q  <= 1'b0;
			tmr_q <= '0;
		end else if (commit && !active_q) begin
			nr_q  <= 1'b1;
			tmr_q <= '0;
		end else if (nr_q) begin
			tmr_q <= tmr_q + 10'h001;
			if (tmr_q == TMR_W'(SETTLE_CYC - 1)) begin
				nr_q <= 1'b0;
			end
		end
	end

	assign fault = ~|stat0[22:1];
	assign stat0 = {1'b1, ov_q, uv_q, tsd_q, tw_q, nr_q, 17'h00000, fault};

	// ==========================================================
	// Output gating
	logic supply_block;
	assign supply_block = ov_s | uv_s | (rec_dis_q & (ov_q | uv_q));

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			outputs_enable_o <= 1'b0;
			standby_o        <= 1'b1;
		end else begin
			outputs_enable_o <= active_q & ~nr_q & ~supply_block & ~tsd_q;
			standby_o        <= ~active_q;
		end
	end

	// ==========================================================
	// Assertions
	sequence s_enter_active;
		!active_q ##1 active_q;
	endsequence

	sequence s_quiet;
		!ov_s && !uv_s && !tsd_s && !tw_s;
	endsequence

	chk_standby_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(commit && !wdata[CTL_ENABLE]) and s_quiet |=> !active_q && !ov_q && !uv_q && !tsd_q
		&& !tw_q && !nr_q)
		else $error("standby write left state");
	chk_reset_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!active_q |=> !outputs_enable_o)
		else $error("outputs on in standby");
	chk_status_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(commit && wdata[CTL_STAT_CLR]) and s_quiet |=> !ov_q && !uv_q && !tsd_q && !tw_q)
		else $error("status reset failed");
	chk_retry_ratio: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		commit |=> overcurrent_retry_ratio_o == $past(wdata[CTL_RATIO]))
		else $error("retry ratio not taken");
	chk_mon_route: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		commit && wdata[CTL_MON_HI:CTL_MON_LO] == MON_OUT1 |=> ##1 current_image_output_o == SRC_OUT1)
		else $error("monitor route wrong");
	chk_always_one: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		sclk_rise && first_q && !di_s |=> out_sh_q[WORD_W-1])
		else $error("status bit 23 not one");
	chk_supply_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(uv_s) |=> uv_q && !outputs_enable_o)
		else $error("undervoltage not handled");
	chk_recovery_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		rec_dis_q && (ov_q || uv_q) |=> !outputs_enable_o)
		else $error("recovery disable ignored");
	chk_tsd_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		tsd_q |=> !outputs_enable_o)
		else $error("outputs on during shutdown");
	chk_warn_noeffect: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		active_q && !nr_q && !supply_block && !tsd_q && tw_q |=> outputs_enable_o)
		else $error("warning blocked outputs");
	chk_notready_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_enter_active |-> nr_q ##1 !outputs_enable_o)
		else $error("not-ready missing");
	chk_notready_end: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(nr_q) |-> nr_q[*8] ##[1:800] !nr_q)
		else $error("settling did not end");
endmodule

// file: bench/ddc_host.sv
// Host model: mode-0 serial master, LSB first, 400 ns bit period.
// Assumes a 50 ns clock on clk_i; the bench calls xfer.
`timescale 1ns/10ps
module ddc_host (
	input  wire logic        clk_i,
	input  wire logic        sdo_i,
	input  wire logic        sdo_oen_i,
	output logic             sck_o,
	output logic             sdi_o,
	output logic             sel_n_o,
	output logic [23:0]      rd_o,
	output int               rd_n_o
);
	logic sdo_last;
	// Released data line shows the inverse of its last value
	wire  line = sdo_oen_i ? ~sdo_last : sdo_i;
	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
		sel_n_o = 1'b1;
		sdo_last = 1'b0;
		rd_n_o = 0;
	end
	always @(posedge sdo_oen_i) sdo_last = sdo_i;
	task automatic hp();
		repeat (4) @(posedge clk_i);
		#2;
	endtask
	// One 24-bit frame, clock idle low outside it
	task automatic xfer(input logic [23:0] w);
		logic [23:0] r;
		sel_n_o = 1'b0;
		for (int i = 0; i < 24; i++) begin
			sdi_o = w[i];
			hp();
			if (i == 0) hp();
			sck_o = 1'b1;
			hp();
			r[i] = line;
			sck_o = 1'b0;
		end
		hp();
		sel_n_o = 1'b1;
		sdi_o = ~sdi_o;
		rd_o = r;
		#1;
		rd_n_o++;
		repeat (8) @(posedge clk_i);
		#2;
	endtask
endmodule

// file: bench/ddc_top_bench.sv
// Self-checking bench for ddc_top with the host model on the link.
// Assumes the hand-over latencies: fields settle 8 clk after select rise.
`timescale 1ns/10ps
module ddc_top_bench;
	import ddc_pkg::*;
	localparam logic [23:0] EN = 24'h800000;
	localparam logic [23:0] CLR = 24'h400000;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        sov = 1'b0, suv = 1'b0, thermal_shutdown_flag = 1'b0, twn = 1'b0;
	logic        sck, sdi, sel_n, sdo, sdo_oen, oe, stby, ratio;
	logic [3:0]  mon;
	logic [3:0]  src [4] = '{SRC_OUT8, SRC_OUT5, SRC_OUT1, SRC_OUT4};
	logic [23:0] rd, ctl;
	logic [23:0] exp_q[$];
	int          rd_n, error_cnt = 0, total_checks = 0, cyc = 0;
	integer      seed = 32'h8ee0a989;
	always #25 clk_sys_i = ~clk_sys_i;
	ddc_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .spi_clk_i(sck),
		.spi_data_in_i(sdi), .frame_select_low_i(sel_n), .supply_over_i(sov),
		.supply_under_i(suv), .thermal_shutdown_i(thermal_shutdown_flag), .thermal_warning_i(twn),
		.spi_data_out_o(sdo), .spi_data_out_oen_o(sdo_oen), .outputs_enable_o(oe),
		.standby_o(stby), .overcurrent_retry_ratio_o(ratio),
		.current_image_output_o(mon));
	ddc_host i_host (.clk_i(clk_sys_i), .sdo_i(sdo), .sdo_oen_i(sdo_oen), .sck_o(sck),
		.sdi_o(sdi), .sel_n_o(sel_n), .rd_o(rd), .rd_n_o(rd_n));
	// ==========================================================
	// Checking
	task automatic chk(input logic [23:0] got, input logic [23:0] want);
		total_checks++;
		if (got !== want) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask
	always @(rd_n) chk(rd, exp_q.pop_front());
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// ==========================================================
	// Stimulus
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask
	task automatic frame(input logic [23:0] w, input logic [23:0] e);
		exp_q.push_back(e);
		i_host.xfer(w);
	endtask
	task automatic fault(ref logic pin, input logic [23:0] e, input logic hold);
		pin = 1'b1;
		tick(8);
		chk(oe, 1'b0);
		pin = 1'b0;
		tick(8);
		chk(oe, !hold);
		frame(ctl | CLR, e);
		tick(2);
		chk(oe, 1'b1);
		$display("fault test done");
	endtask
	initial begin
		tick(3);
		rstn_i = 1'b1;
		tick(2);
		chk(stby, 1'b1);
		chk(oe, 1'b0);
		chk(sdo_oen, 1'b1);
		ctl = EN;
		frame(ctl, 24'h800001);
		chk(stby, 1'b0);
		frame(ctl, 24'h840000);
		chk(oe, 1'b0);
		tick(700);
		chk(oe, 1'b1);
		frame(ctl, 24'h800001);
		$display("settle test done");
		for (int c = 0; c < 4; c++) begin
			ctl = EN | (24'(c) << CTL_MON_LO) | (24'($random(seed) & 1) << CTL_RATIO);
			frame(ctl, 24'h800001);
			chk(mon, src[c]);
			chk(ratio, ctl[CTL_RATIO]);
		end
		frame(24'h000001, 24'h000001);
		chk(stby, 1'b0);
		$display("field test done");
		fault(sov, 24'hc00000, 1'b0);
		ctl[CTL_REC_DIS] = 1'b1;
		frame(ctl, 24'h800001);
		fault(suv, 24'ha00000, 1'b1);
		fault(thermal_shutdown_flag, 24'h900000, 1'b1);
		twn = 1'b1;
		tick(8);
		frame(ctl, 24'h880000);
		chk(oe, 1'b1);
		twn = 1'b0;
		ctl = 24'h0;
		frame(ctl, 24'h880000);
		chk(stby, 1'b1);
		chk(oe, 1'b0);
		frame(ctl, 24'h800001);
		chk(24'(exp_q.size()), 24'h0);
		$display("standby test done");
		close_out();
	end
endmodule
